//--- qdc_top.sv
// quad dac configuration and output-update control with axi4-lite registers
`timescale 1ns/1ns
`include "qdc_map.svh"

// What this block does
// - ready flag: 1 idle, 0 programming
// - ready flag also driven on a pin
// - reference bit: 0 supply, 1 internal
// - internal reference off when all use supply
// - channel select 00..11 picks A..D
// - power-down codes pick 1k/100k/500k load
// - gain 2 only with internal reference
// - latch bit 0 copies selected channel
// - load pin low updates all channels
// - load pin high: latch bit decides
// - software update copies all channels together
// - resets load input and output from storage
// - fast write ignores the latch bit
// - internal: 2.048V*code/4096*gain, clipped to supply
// - supply reference: supply*code/4096, unity gain
// - step 0.5 mV x1, 1 mV x2
// - each channel runs from its own settings
// - reset loads ignore pin and latch bit
module qdc_top #(
  parameter int NCH = 4,
  // programming time in clocks, rounded up
  parameter int NV_PROG_CYC = (`QDC_NV_PROG_NS * `QDC_CLK_MHZ + 999) / 1000
) (
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [7:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  // device pin, supply level and the per-channel analog-side views
  input wire logic all_channel_load_pin_n,
  input wire logic [12:0] supply_mv,
  output logic nv_program_status_flag,
  output logic internal_ref_enable,
  output qdc_pkg::qdc_cfg_s [NCH-1:0] out_cfg,
  output logic [NCH-1:0][22:0] vout_uv,
  output logic [NCH-1:0][1:0] load_sel
);

  qdc_pkg::qdc_cfg_s [NCH-1:0] in_reg, in_next;
  qdc_pkg::qdc_cfg_s [NCH-1:0] out_reg, out_next;
  qdc_pkg::qdc_cfg_s [NCH-1:0] nv_reg, nv_next;
  // copy of the input registers taken when programming starts
  qdc_pkg::qdc_cfg_s [NCH-1:0] shadow_reg, shadow_next;
  qdc_pkg::qdc_nv_e nv_state_reg, nv_state_next;
  logic [31:0] nv_cnt_reg, nv_cnt_next;
  logic ready_reg, ready_next;
  logic iref_reg, iref_next;
  logic por_reg, por_next;

  // one-cycle write strobe from the bus front end, with the word it carries
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  qdc_pkg::qdc_cmd_s cmd;
  logic cmd_wr;
  logic ctrl_wr;
  logic sw_update;
  logic gc_reset;
  logic nv_start;
  logic [1:0] sel;

  // true when the address falls in a four-word per-channel window
  function automatic logic in_window(input logic [7:0] a, input logic [7:0] base);
    in_window = (a >= base) && (a < base + 8'(NCH * 4)) && (a[1:0] == 2'b00);
  endfunction : in_window

  function automatic logic [1:0] win_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    win_idx = d[3:2];
  endfunction : win_idx

  // pads one channel setting out to a bus word
  function automatic logic [31:0] cfg_word(input qdc_pkg::qdc_cfg_s c);
    cfg_word = {16'h0000, c};
  endfunction : cfg_word

  // bus front end: one write and one read in flight
  qdc_axil u_axil (
    .clk(clk),
    .srst(srst),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_bresp(s_bresp),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_araddr(s_araddr),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // write decode
  always_comb begin
    cmd = wr_data;
    cmd_wr = 1'b0;
    ctrl_wr = 1'b0;
    wr_ok = 1'b0;
    if (wr_addr == `QDC_OFF_CTRL) begin
      ctrl_wr = wr_pulse;
      wr_ok = 1'b1;
    end else if (wr_addr == `QDC_OFF_CMD) begin
      cmd_wr = wr_pulse;
      wr_ok = 1'b1;
    end else if (wr_addr == `QDC_OFF_STATUS) begin
      // read-only words answer okay and are left alone
      wr_ok = 1'b1;
    end else if (in_window(wr_addr, `QDC_OFF_IN_BASE)) begin
      wr_ok = 1'b1;
    end else if (in_window(wr_addr, `QDC_OFF_OUT_BASE)) begin
      wr_ok = 1'b1;
    end else if (in_window(wr_addr, `QDC_OFF_NV_BASE)) begin
      wr_ok = 1'b1;
    end
    // control bits act only in the strobe cycle; nothing is kept for later
    sw_update = ctrl_wr && wr_data[`QDC_CTRL_SW_UPDATE];
    gc_reset = ctrl_wr && wr_data[`QDC_CTRL_GC_RESET];
    nv_start = ctrl_wr && wr_data[`QDC_CTRL_NV_PROGRAM];
    sel = cmd.channel_select_field;
  end

  // read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b0;
    if (rd_addr == `QDC_OFF_CTRL) begin
      // control and command words are write-only and read back as zero
      rd_ok = 1'b1;
    end else if (rd_addr == `QDC_OFF_CMD) begin
      rd_ok = 1'b1;
    end else if (rd_addr == `QDC_OFF_STATUS) begin
      rd_data[`QDC_STAT_READY] = ready_reg;
      rd_data[`QDC_STAT_IREF_EN] = iref_reg;
      rd_data[`QDC_STAT_LOAD_PIN] = all_channel_load_pin_n;
      rd_ok = 1'b1;
    end else if (in_window(rd_addr, `QDC_OFF_IN_BASE)) begin
      rd_data = cfg_word(in_reg[win_idx(rd_addr, `QDC_OFF_IN_BASE)]);
      rd_ok = 1'b1;
    end else if (in_window(rd_addr, `QDC_OFF_OUT_BASE)) begin
      rd_data = cfg_word(out_reg[win_idx(rd_addr, `QDC_OFF_OUT_BASE)]);
      rd_ok = 1'b1;
    end else if (in_window(rd_addr, `QDC_OFF_NV_BASE)) begin
      rd_data = cfg_word(nv_reg[win_idx(rd_addr, `QDC_OFF_NV_BASE)]);
      rd_ok = 1'b1;
    end
  end

  // input and output registers of every channel
  always_comb begin
    in_next = in_reg;
    out_next = out_reg;
    por_next = 1'b0;
    if (por_reg || gc_reset) begin
      // stored settings go straight to both registers, pin and latch bit ignored
      in_next = nv_reg;
      out_next = nv_reg;
    end else begin
      if (cmd_wr) begin
        in_next[sel] = cmd.cfg;
        // a fast write never consults the latch bit
        if (!cmd.fast_write && !cmd.single_channel_latch_bit) begin
          out_next[sel] = cmd.cfg;
        end
      end
      // copy from in_next, not in_reg: a word written while the pin is low
      // reaches its output on the same edge instead of one cycle later
      if (!all_channel_load_pin_n || sw_update) begin
        out_next = in_next;
      end
    end
  end

  // internal reference runs while any channel asks for it
  // built from out_next so the enable moves on the same edge as the outputs
  always_comb begin
    iref_next = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      iref_next = iref_next | out_next[i].ref_int;
    end
  end

  // nonvolatile programming: captured at start, committed when the busy time ends
  // a general-call reset does not abort it; storage changes only at the end
  always_comb begin
    nv_state_next = nv_state_reg;
    nv_cnt_next = nv_cnt_reg;
    nv_next = nv_reg;
    shadow_next = shadow_reg;
    ready_next = ready_reg;
    case (nv_state_reg)
      qdc_pkg::NV_IDLE: begin
        if (nv_start) begin
          nv_state_next = qdc_pkg::NV_BUSY;
          // one less, so the flag stays low for exactly NV_PROG_CYC cycles
          nv_cnt_next = 32'(NV_PROG_CYC - 1);
          shadow_next = in_reg;
          ready_next = 1'b0;
        end
      end
      qdc_pkg::NV_BUSY: begin
        if (nv_cnt_reg == 32'd0) begin
          nv_state_next = qdc_pkg::NV_IDLE;
          nv_next = shadow_reg;
          ready_next = 1'b1;
        end else begin
          nv_cnt_next = nv_cnt_reg - 32'd1;
        end
      end
      default: begin
        // unreachable with two states; falls back to idle
        nv_state_next = qdc_pkg::NV_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      // storage has no cells behind it here, so reset restores the factory word
      for (int i = 0; i < NCH; i++) begin
        in_reg[i] <= `QDC_CFG_RST;
        out_reg[i] <= `QDC_CFG_RST;
        nv_reg[i] <= `QDC_CFG_RST;
        shadow_reg[i] <= `QDC_CFG_RST;
      end
      // asks for one reload from storage on the first edge after release
      por_reg <= 1'b1;
      nv_state_reg <= qdc_pkg::NV_IDLE;
      nv_cnt_reg <= 32'd0;
      ready_reg <= 1'b1;
      iref_reg <= 1'b1;
    end else begin
      in_reg <= in_next;
      out_reg <= out_next;
      nv_reg <= nv_next;
      shadow_reg <= shadow_next;
      por_reg <= por_next;
      nv_state_reg <= nv_state_next;
      nv_cnt_reg <= nv_cnt_next;
      ready_reg <= ready_next;
      iref_reg <= iref_next;
    end
  end

  // pin and status bit come from one flop, so they never disagree
  assign nv_program_status_flag = ready_reg;
  assign internal_ref_enable = iref_reg;
  assign out_cfg = out_reg;

  // each converter sees only its own output register, never the input side
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    qdc_channel u_ch (
      .clk(clk),
      .srst(srst),
      .cfg(out_reg[g]),
      .supply_mv(supply_mv),
      .vout_uv(vout_uv[g]),
      .load_sel(load_sel[g])
    );
  end

endmodule : qdc_top

//--- qdc_map.svh
// register offsets, field positions, reset values and timing for the quad dac control
`ifndef QDC_MAP_SVH
`define QDC_MAP_SVH

`define QDC_ADDR_W 8
`define QDC_OFF_CTRL 8'h00
`define QDC_OFF_CMD 8'h04
`define QDC_OFF_STATUS 8'h08
`define QDC_OFF_IN_BASE 8'h10
`define QDC_OFF_OUT_BASE 8'h20
`define QDC_OFF_NV_BASE 8'h30

`define QDC_CTRL_SW_UPDATE 0
`define QDC_CTRL_GC_RESET 1
`define QDC_CTRL_NV_PROGRAM 2

`define QDC_STAT_READY 0
`define QDC_STAT_IREF_EN 1
`define QDC_STAT_LOAD_PIN 2

`define QDC_CFG_RST 16'h8000
`define QDC_CODE_FULL 4096

`define QDC_CLK_MHZ 125
`define QDC_NV_PROG_NS 50000
`define QDC_LSB_X1_UV 500
`define QDC_LSB_X2_UV 1000
`define QDC_UV_PER_MV 1000

`endif

//--- qdc_pkg.sv
// types shared by the quad dac control block
package qdc_pkg;

  typedef struct packed {
    logic ref_int;
    logic [1:0] powerdown_load_select;
    logic output_gain_select;
    logic [11:0] code;
  } qdc_cfg_s;

  typedef struct packed {
    logic [11:0] unused;
    logic fast_write;
    logic single_channel_latch_bit;
    logic [1:0] channel_select_field;
    qdc_cfg_s cfg;
  } qdc_cmd_s;

  typedef enum logic [0:0] {
    NV_IDLE,
    NV_BUSY
  } qdc_nv_e;

endpackage : qdc_pkg

//--- qdc_channel.sv
// one dac channel: code to output voltage in microvolts and power-down load select
`timescale 1ns/1ns
`include "qdc_map.svh"

module qdc_channel (
  input wire logic clk,
  input wire logic srst,
  input qdc_pkg::qdc_cfg_s cfg,
  input wire logic [12:0] supply_mv,
  output logic [22:0] vout_uv,
  output logic [1:0] load_sel
);

  logic [22:0] vout_next;
  logic [1:0] load_next;
  logic [34:0] supply_uv;
  logic [34:0] prod;

  always_comb begin
    supply_uv = 35'(supply_mv) * 35'(`QDC_UV_PER_MV);
    prod = 35'd0;
    if (cfg.ref_int) begin
      // gain 2 only exists with the internal reference
      if (cfg.output_gain_select) begin
        prod = 35'(cfg.code) * 35'(`QDC_LSB_X2_UV);
      end else begin
        prod = 35'(cfg.code) * 35'(`QDC_LSB_X1_UV);
      end
      if (prod > supply_uv) begin
        prod = supply_uv;
      end
    end else begin
      prod = (supply_uv * 35'(cfg.code)) / 35'(`QDC_CODE_FULL);
    end
    load_next = cfg.powerdown_load_select;
    if (cfg.powerdown_load_select != 2'b00) begin
      vout_next = 23'd0;
    end else begin
      vout_next = prod[22:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vout_uv <= 23'd0;
      load_sel <= 2'b00;
    end else begin
      vout_uv <= vout_next;
      load_sel <= load_next;
    end
  end

endmodule : qdc_channel

//--- qdc_axil.sv
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/1ns
`include "qdc_map.svh"

module qdc_axil (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [7:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic wr_pulse,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_free_next, w_free_next, b_next, ar_free_next, r_next;
  logic [7:0] aw_addr_next;
  logic [31:0] w_data_next, r_data_next;
  logic [1:0] bresp_next, rresp_next;

  function automatic logic [31:0] strb_mask(input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      strb_mask[i*8 +: 8] = s[i] ? d[i*8 +: 8] : 8'h00;
    end
  endfunction : strb_mask

  assign wr_pulse = !s_awready && !s_wready && !s_bvalid;
  assign rd_addr = s_araddr;

  always_comb begin
    aw_free_next = s_awready;
    w_free_next = s_wready;
    aw_addr_next = wr_addr;
    w_data_next = wr_data;
    b_next = s_bvalid;
    bresp_next = s_bresp;
    ar_free_next = s_arready;
    r_next = s_rvalid;
    r_data_next = s_rdata;
    rresp_next = s_rresp;
    if (s_awvalid && s_awready) begin
      aw_free_next = 1'b0;
      aw_addr_next = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_free_next = 1'b0;
      w_data_next = strb_mask(s_wdata, s_wstrb);
    end
    if (s_bvalid && s_bready) begin
      b_next = 1'b0;
      aw_free_next = 1'b1;
      w_free_next = 1'b1;
    end
    if (wr_pulse) begin
      b_next = 1'b1;
      bresp_next = wr_ok ? 2'b00 : 2'b10;
    end
    if (s_arvalid && s_arready) begin
      ar_free_next = 1'b0;
      r_next = 1'b1;
      r_data_next = rd_ok ? rd_data : 32'h0000_0000;
      rresp_next = rd_ok ? 2'b00 : 2'b10;
    end
    if (s_rvalid && s_rready) begin
      r_next = 1'b0;
      ar_free_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      s_bvalid <= 1'b0;
      s_bresp <= 2'b00;
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'b00;
    end else begin
      s_awready <= aw_free_next;
      s_wready <= w_free_next;
      wr_addr <= aw_addr_next;
      wr_data <= w_data_next;
      s_bvalid <= b_next;
      s_bresp <= bresp_next;
      s_arready <= ar_free_next;
      s_rvalid <= r_next;
      s_rdata <= r_data_next;
      s_rresp <= rresp_next;
    end
  end

endmodule : qdc_axil

//--- qdc_asserts.sv
// concurrent checks on the quad dac control top ports
`timescale 1ns/1ns
`include "qdc_map.svh"

module qdc_asserts #(
  parameter int NCH = 4,
  parameter int NV_PROG_CYC = 4
) (
  input logic clk,
  input logic srst,
  input logic s_awvalid,
  input logic s_awready,
  input logic s_wvalid,
  input logic s_wready,
  input logic s_bvalid,
  input logic s_bready,
  input logic s_arvalid,
  input logic s_arready,
  input logic s_rvalid,
  input logic s_rready,
  input logic all_channel_load_pin_n,
  input logic [12:0] supply_mv,
  input logic nv_program_status_flag,
  input logic internal_ref_enable,
  input qdc_pkg::qdc_cfg_s [NCH-1:0] out_cfg,
  input logic [NCH-1:0][22:0] vout_uv,
  input logic [NCH-1:0][1:0] load_sel
);
  logic [NCH-1:0] refs;
  logic [NCH-1:0][1:0] pds;
  logic [NCH-1:0][22:0] ev;
  int busy;

  function automatic logic [22:0] vexp(input qdc_pkg::qdc_cfg_s c, input logic [12:0] s);
    longint v;
    longint top;
    top = longint'(s) * `QDC_UV_PER_MV;
    if (c.powerdown_load_select != 2'h0) v = '0;
    else if (!c.ref_int) v = top * c.code / `QDC_CODE_FULL;
    else v = c.code * (c.output_gain_select ? `QDC_LSB_X2_UV : `QDC_LSB_X1_UV);
    // the internal path can ask for more than the rail; clip to supply
    if (v > top) v = top;
    return v[22:0];
  endfunction : vexp

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      refs[i] = out_cfg[i].ref_int;
      pds[i] = out_cfg[i].powerdown_load_select;
      ev[i] = vexp(out_cfg[i], supply_mv);
    end
  end

  // cycles the ready flag has spent low
  always_ff @(posedge clk) busy <= (srst || nv_program_status_flag) ? 0 : busy + 1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_iref; $stable(out_cfg) |-> internal_ref_enable == (|refs); endproperty
  a_iref: assert property (p_iref)
    else $error("reference enable mismatch");
  property p_ldsel; !$past(srst) |-> load_sel == $past(pds); endproperty
  a_ldsel: assert property (p_ldsel)
    else $error("load select mismatch");
  property p_vout; !$past(srst) |-> vout_uv == $past(ev); endproperty
  a_vout: assert property (p_vout)
    else $error("output voltage mismatch");
  property p_hold;
    !$rose(s_bvalid) && all_channel_load_pin_n && $past(all_channel_load_pin_n)
      && $past(all_channel_load_pin_n, 2) && $past(all_channel_load_pin_n, 3)
      && !$past(srst) && !$past(srst, 2) |-> $stable(out_cfg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed without update event");
  property p_busy;
    $rose(nv_program_status_flag) |-> busy >= NV_PROG_CYC - 1 && busy <= NV_PROG_CYC + 1;
  endproperty
  a_busy: assert property (p_busy)
    else $error("programming busy span wrong");
  property p_bkeep; s_bvalid && !s_bready |=> s_bvalid; endproperty
  a_bkeep: assert property (p_bkeep)
    else $error("write response dropped early");
  property p_rkeep; s_rvalid && !s_rready |=> s_rvalid; endproperty
  a_rkeep: assert property (p_rkeep)
    else $error("read data dropped early");
  property p_bwait; s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid; endproperty
  a_bwait: assert property (p_bwait)
    else $error("write response late");
  property p_rwait; s_arvalid && s_arready |=> s_rvalid; endproperty
  a_rwait: assert property (p_rwait)
    else $error("read data late");

  c_nv: cover property ($rose(nv_program_status_flag));
  c_pin: cover property (!all_channel_load_pin_n && $changed(out_cfg));
  c_pd: cover property (load_sel[0] != 2'h0);
endmodule : qdc_asserts

bind qdc_top qdc_asserts #(.NCH(NCH), .NV_PROG_CYC(NV_PROG_CYC)) i_chk (.*);

//--- qdc_bus_master.sv
// axi4-lite master standing in for the controller that sends configuration
`timescale 1ns/1ns

module qdc_bus_master (
  input logic clk,
  output logic s_awvalid,
  input logic s_awready,
  output logic [7:0] s_awaddr,
  output logic s_wvalid,
  input logic s_wready,
  output logic [31:0] s_wdata,
  output logic [3:0] s_wstrb,
  input logic s_bvalid,
  output logic s_bready,
  input logic [1:0] s_bresp,
  output logic s_arvalid,
  input logic s_arready,
  output logic [7:0] s_araddr,
  input logic s_rvalid,
  output logic s_rready,
  input logic [31:0] s_rdata,
  input logic [1:0] s_rresp
);
  // cycles before bready/rready rise, so the slave also meets a slow master
  int lag;

  initial begin
    lag = 0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_wdata, s_wstrb, s_araddr} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    forever begin
      @(posedge clk);
      n++;
      // released lines show the inverse, never the stale value
      if (s_awvalid && s_awready) begin
        s_awvalid <= 1'h0;
        s_awaddr <= ~a;
      end
      if (s_wvalid && s_wready) begin
        s_wvalid <= 1'h0;
        s_wdata <= ~d;
      end
      if (s_bvalid && s_bready) begin
        r = s_bresp;
        s_bready <= 1'h0;
        break;
      end
      if (n > lag) s_bready <= 1'h1;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'h1;
    forever begin
      @(posedge clk);
      n++;
      if (s_arvalid && s_arready) begin
        s_arvalid <= 1'h0;
        s_araddr <= ~a;
      end
      if (s_rvalid && s_rready) begin
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'h0;
        break;
      end
      if (n > lag) s_rready <= 1'h1;
    end
  endtask : rd
endmodule : qdc_bus_master

//--- quad_dac_config_update_tb_top.sv
// self-checking bench for the quad dac configuration and update block
`timescale 1ns/1ns
`include "qdc_map.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module quad_dac_config_update_tb_top;
  logic clk, srst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, all_channel_load_pin_n;
  logic nv_program_status_flag, internal_ref_enable;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, r;
  logic [12:0] supply_mv;
  qdc_pkg::qdc_cfg_s [3:0] out_cfg;
  logic [3:0][22:0] vout_uv;
  logic [3:0][1:0] load_sel;
  logic [15:0] in_m [4], out_m [4], nv_m [4];
  logic [15:0] tc [4] = '{16'h9fff, 16'h9100, 16'h8100, 16'h1800};
  logic [22:0] tv [4] = '{23'h32_5aa0, 23'h3_e800, 23'h1_f400, 23'h19_2d50};
  int fail_count, checks_done;

  qdc_top #(.NV_PROG_CYC(20)) i_dut (.*);
  qdc_bus_master i_mst (.*);

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    i_mst.wr(a, v, r);
    `CHK(r, er)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    i_mst.rd(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask : rd

  task automatic cmd(input logic [1:0] ch, input logic [15:0] c, input logic lat, input logic f);
    wr(`QDC_OFF_CMD, {12'h000, f, lat, ch, c}, 2'h0);
    in_m[ch] = c;
    if (!lat && !f) out_m[ch] = c;
  endtask : cmd

  task automatic rst_models;
    for (int i = 0; i < 4; i++) begin
      in_m[i] = `QDC_CFG_RST;
      out_m[i] = `QDC_CFG_RST;
      nv_m[i] = `QDC_CFG_RST;
    end
  endtask : rst_models

  task automatic chk;
    for (int i = 0; i < 4; i++) begin
      rd(`QDC_OFF_IN_BASE + 8'(4 * i), {16'h0000, in_m[i]}, 2'h0);
      rd(`QDC_OFF_NV_BASE + 8'(4 * i), {16'h0000, nv_m[i]}, 2'h0);
      `CHK(out_cfg[i], out_m[i])
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim;
  end

  initial begin
    srst = 1'h1;
    all_channel_load_pin_n = 1'h1;
    supply_mv = 13'h0ce4;
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    rst_models;
    @(posedge clk);
    chk;
    rd(`QDC_OFF_STATUS, 32'h0000_0007, 2'h0);
    for (int i = 0; i < 4; i++) begin
      cmd(2'(i), 16'h8200 + 16'(i), 1'h1, 1'h0);
      chk;
      cmd(2'(i), 16'h8100 + 16'(i), 1'h0, 1'h0);
      chk;
    end
    i_mst.lag = 3;
    cmd(2'h1, 16'h9abc, 1'h0, 1'h1);
    cmd(2'h2, 16'h8abc, 1'h1, 1'h0);
    chk;
    wr(`QDC_OFF_CTRL, 32'h0000_0001, 2'h0);
    out_m = in_m;
    chk;
    wr(8'h40, 32'h0000_0001, 2'h2);
    rd(8'h40, 32'h0000_0000, 2'h2);
    i_mst.lag = 0;
    all_channel_load_pin_n <= 1'h0;
    cmd(2'h3, 16'h8123, 1'h1, 1'h0);
    repeat (2) @(posedge clk);
    out_m = in_m;
    chk;
    all_channel_load_pin_n <= 1'h1;
    repeat (4) @(posedge clk);
    for (int p = 0; p < 4; p++) begin
      cmd(2'h3, {1'h1, 2'(p), 13'h0010}, 1'h0, 1'h0);
      repeat (2) @(posedge clk);
      `CHK(load_sel[3], 2'(p))
    end
    for (int k = 0; k < 4; k++) begin
      cmd(2'h0, tc[k], 1'h0, 1'h0);
      repeat (2) @(posedge clk);
      `CHK(vout_uv[0], tv[k])
    end
    for (int i = 0; i < 4; i++) cmd(2'(i), 16'h0010, 1'h0, 1'h0);
    repeat (2) @(posedge clk);
    `CHK(internal_ref_enable, 1'h0)
    rd(`QDC_OFF_STATUS, 32'h0000_0005, 2'h0);
    cmd(2'h2, 16'h8010, 1'h0, 1'h0);
    repeat (2) @(posedge clk);
    `CHK(internal_ref_enable, 1'h1)
    wr(`QDC_OFF_CTRL, 32'h0000_0004, 2'h0);
    nv_m = in_m;
    repeat (2) @(posedge clk);
    `CHK(nv_program_status_flag, 1'h0)
    rd(`QDC_OFF_STATUS, 32'h0000_0006, 2'h0);
    for (int n = 0; n < 40 && nv_program_status_flag !== 1'h1; n++) @(posedge clk);
    `CHK(nv_program_status_flag, 1'h1)
    cmd(2'h0, 16'h8555, 1'h0, 1'h0);
    wr(`QDC_OFF_CTRL, 32'h0000_0002, 2'h0);
    in_m = nv_m;
    out_m = nv_m;
    chk;
    cmd(2'h1, 16'h8777, 1'h0, 1'h0);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    rst_models;
    @(posedge clk);
    chk;
    end_sim;
  end
endmodule : quad_dac_config_update_tb_top
